// >>> core/opmode_pkg.sv
// Constants, types and carriers of the operating-mode controller.
// Assumes a single 40 MHz clock and an external SPI frame decoder.
package opmode_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS    = 25;
   localparam int STRAP_FILTER_NS  = 1000;
   localparam int STRAP_FILTER_CYC = (STRAP_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TEST_FILTER_NS   = 1000;
   localparam int TEST_FILTER_CYC  = (TEST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Recovery frames and mode codes
   // ---------------------------------------------------------------
   localparam logic [7:0]  CRC_ON_ADDR  = 8'h67;
   localparam logic [7:0]  CRC_ON_CHK   = 8'h0e;
   localparam logic [7:0]  CRC_OFF_ADDR = 8'he7;
   localparam logic [7:0]  CRC_OFF_CHK  = 8'hc3;
   localparam logic [15:0] RECOV_DATA   = 16'haaaa;
   localparam int          RW_BIT       = 7;
   localparam logic [1:0]  REQ_NORMAL   = 2'h0;
   localparam logic [1:0]  REQ_SLEEP    = 2'h1;
   localparam logic [1:0]  REQ_STOP     = 2'h2;
   localparam logic [1:0]  REQ_SOFT_RST = 2'h3;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic CRC_EN_RST   = 1'b0;
   localparam logic STRAP_RST    = 1'b1;
   localparam logic TEST_PIN_RST = 1'b1;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_INIT    = 3'b000,
      MODE_NORMAL  = 3'b001,
      MODE_STOP    = 3'b010,
      MODE_SLEEP   = 3'b011,
      MODE_RESTART = 3'b100
   } mode_t;

   typedef enum logic [1:0] {
      KIND_OTHER  = 2'b00,
      KIND_MODE   = 2'b01,
      KIND_WD_REF = 2'b10,
      KIND_STATUS = 2'b11
   } frame_kind_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  addr_rw;
      logic [15:0] data;
      logic [7:0]  check;
      frame_kind_t kind;
   } frame_t;

   typedef struct packed {
      logic       wd_en;
      logic       hs_en;
      logic       bridge_en;
      logic       pump_en;
      logic       amp_en;
      logic       lin_on;
      logic       lin_wake;
      logic       cs_en;
      logic [1:0] cs_src;
      logic       cw_en;
      logic       cw_src;
   } cfg_t;

   typedef struct packed {
      logic       main_reg_on;
      logic       wd_en;
      logic       wd_fixed;
      logic       hs_en;
      logic       bridge_en;
      logic       ls_brake;
      logic       pump_en;
      logic       amp_en;
      logic       lin_on;
      logic       lin_wake;
      logic       cs_en;
      logic [1:0] cs_src;
      logic       cw_en;
      logic       cw_src;
   } enables_t;

endpackage

// >>> core/pin_filter.sv
// Three-stage pin synchroniser with a stability filter.
// Assumes an asynchronous pin level and the block clock.
`timescale 1ns/1ps
module pin_filter #(
   parameter int   CYCLES = 4,
   parameter logic INIT   = 1'b1
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic pin,
   output logic      filt
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [2:0]    sync;
   logic [2:0]    next_sync;
   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic          next_filt;

   // ---------------------------------------------------------------
   // Filter
   // ---------------------------------------------------------------
   always_comb begin
      next_sync = {sync[1:0], pin};
      next_cnt  = '0;
      next_filt = filt;
      if (sync[1] == sync[2] && sync[2] != filt) begin
         if (cnt == CW'(CYCLES - 1)) begin
            next_filt = sync[2];
         end else begin
            next_cnt = cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sync <= {3{INIT}};
         cnt  <= '0;
         filt <= INIT;
      end else begin
         sync <= next_sync;
         cnt  <= next_cnt;
         filt <= next_filt;
      end
   end
endmodule

// >>> core/operating_mode_controller.sv
// Operating-mode controller: mode state, enables, CRC strap, frame filter.
// Assumes an SPI decoder on clk that classifies frames and holds registers.
`timescale 1ns/1ps
module operating_mode_controller #(
   parameter int STRAP_CYC = opmode_pkg::STRAP_FILTER_CYC,
   parameter int TEST_CYC  = opmode_pkg::TEST_FILTER_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire logic                 main_reg_ok,
   input  wire logic                 por_flag,
   input  wire logic                 reset_out_level,
   input  wire logic                 restart_req,
   input  wire logic                 crc_strap_pin,
   input  wire logic                 int_test_pin,
   input  wire opmode_pkg::frame_t   frame,
   input  wire logic                 crc_mismatch,
   input  wire logic                 fault_clear,
   input  wire opmode_pkg::cfg_t     cfg,
   input  wire logic                 park_brake_req,
   input  wire logic                 ov_brake_req,
   input  wire logic [3:0]           wake_events,
   input  wire logic [3:0]           wake_mask,
   output opmode_pkg::mode_t         mode,
   output opmode_pkg::enables_t      en,
   output logic                      crc_en,
   output logic                      sdm,
   output logic                      spi_fault,
   output logic                      write_accept,
   output logic                      soft_reset,
   output logic                      wd_start,
   output logic                      int_req
);
   opmode_pkg::mode_t next_mode;
   opmode_pkg::cfg_t  frozen;
   opmode_pkg::cfg_t  next_frozen;
   logic              next_crc_en;
   logic              next_sdm;
   logic              next_fault;
   logic              next_accept;
   logic              next_soft;
   logic              next_wd_start;
   logic              from_pu;
   logic              next_from_pu;
   logic              rst_q;
   logic              next_rst_q;
   logic              eval_q;
   logic              next_eval;
   logic              strap_filt;
   logic              test_filt;
   logic              is_write;
   logic              rst_rise;
   logic              eval_ok;
   logic              stop_allowed;
   logic              frm_on;
   logic              frm_off;
   logic [1:0]        req;

   // ---------------------------------------------------------------
   // Pin filters
   // ---------------------------------------------------------------
   pin_filter #(.CYCLES(STRAP_CYC), .INIT(opmode_pkg::STRAP_RST)) u_strap (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (crc_strap_pin),
      .filt    (strap_filt)
   );

   pin_filter #(.CYCLES(TEST_CYC), .INIT(opmode_pkg::TEST_PIN_RST)) u_test (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (int_test_pin),
      .filt    (test_filt)
   );

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   assign is_write = frame.valid && frame.addr_rw[opmode_pkg::RW_BIT];
   assign req      = frame.data[1:0];
   assign rst_rise = reset_out_level && !rst_q;
   assign eval_ok  = ((mode == opmode_pkg::MODE_INIT && from_pu) ||
                      mode == opmode_pkg::MODE_RESTART) &&
                     main_reg_ok && por_flag && !reset_out_level;
   assign frm_on   = frame.valid && frame.addr_rw == opmode_pkg::CRC_ON_ADDR &&
                     frame.data == opmode_pkg::RECOV_DATA &&
                     frame.check == opmode_pkg::CRC_ON_CHK;
   assign frm_off  = frame.valid && frame.addr_rw == opmode_pkg::CRC_OFF_ADDR &&
                     frame.data == opmode_pkg::RECOV_DATA &&
                     frame.check == opmode_pkg::CRC_OFF_CHK;
   assign stop_allowed = frame.kind == opmode_pkg::KIND_WD_REF ||
                         frame.kind == opmode_pkg::KIND_STATUS ||
                         (frame.kind == opmode_pkg::KIND_MODE &&
                          (req == opmode_pkg::REQ_NORMAL ||
                           req == opmode_pkg::REQ_SOFT_RST));

   // ---------------------------------------------------------------
   // Mode, CRC and write filter
   // ---------------------------------------------------------------
   always_comb begin
      next_mode     = mode;
      next_accept   = 1'b0;
      next_soft     = 1'b0;
      next_fault    = spi_fault;
      next_crc_en   = crc_en;
      next_sdm      = sdm;
      next_from_pu  = from_pu;
      next_rst_q    = reset_out_level;
      next_eval     = eval_ok;
      next_wd_start = rst_rise && mode == opmode_pkg::MODE_INIT;
      next_frozen   = frozen;
      if (fault_clear) begin
         next_fault = 1'b0;
      end
      unique case (mode)
         opmode_pkg::MODE_INIT, opmode_pkg::MODE_NORMAL: begin
            if (mode == opmode_pkg::MODE_NORMAL) begin
               next_frozen = cfg;
            end
            if (is_write) begin
               next_accept = 1'b1;
               if (frame.kind == opmode_pkg::KIND_MODE) begin
                  unique case (req)
                     opmode_pkg::REQ_NORMAL:   next_mode = opmode_pkg::MODE_NORMAL;
                     opmode_pkg::REQ_SLEEP:    next_mode = opmode_pkg::MODE_SLEEP;
                     opmode_pkg::REQ_STOP:     next_mode = opmode_pkg::MODE_STOP;
                     opmode_pkg::REQ_SOFT_RST: begin
                        next_mode = opmode_pkg::MODE_INIT;
                        next_soft = 1'b1;
                     end
                  endcase
               end
            end
         end
         opmode_pkg::MODE_STOP: begin
            if (is_write) begin
               if (stop_allowed) begin
                  next_accept = 1'b1;
                  if (frame.kind == opmode_pkg::KIND_MODE) begin
                     if (req == opmode_pkg::REQ_SOFT_RST) begin
                        next_mode = opmode_pkg::MODE_INIT;
                        next_soft = 1'b1;
                     end else begin
                        next_mode = opmode_pkg::MODE_NORMAL;
                     end
                  end
               end else begin
                  next_fault = 1'b1;
               end
            end
         end
         opmode_pkg::MODE_SLEEP: begin
         end
         opmode_pkg::MODE_RESTART: begin
            if (rst_rise) begin
               next_mode = opmode_pkg::MODE_NORMAL;
            end
         end
         default: begin
            next_mode = opmode_pkg::MODE_INIT;
         end
      endcase
      if (restart_req) begin
         next_mode = opmode_pkg::MODE_RESTART;
      end
      if (mode != opmode_pkg::MODE_INIT) begin
         next_from_pu = 1'b0;
      end
      if (rst_rise && eval_q) begin
         next_crc_en = !strap_filt;
      end else if (mode == opmode_pkg::MODE_NORMAL && crc_mismatch) begin
         if (frm_on) begin
            next_crc_en = 1'b1;
         end else if (frm_off) begin
            next_crc_en = 1'b0;
         end
      end
      if (mode == opmode_pkg::MODE_INIT && from_pu && main_reg_ok && por_flag &&
          reset_out_level && !test_filt && frame.valid) begin
         next_sdm = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode         <= opmode_pkg::MODE_INIT;
         crc_en       <= opmode_pkg::CRC_EN_RST;
         sdm          <= 1'b0;
         spi_fault    <= 1'b0;
         write_accept <= 1'b0;
         soft_reset   <= 1'b0;
         wd_start     <= 1'b0;
         from_pu      <= 1'b1;
         rst_q        <= 1'b0;
         eval_q       <= 1'b0;
         frozen       <= '0;
      end else begin
         mode         <= next_mode;
         crc_en       <= next_crc_en;
         sdm          <= next_sdm;
         spi_fault    <= next_fault;
         write_accept <= next_accept;
         soft_reset   <= next_soft;
         wd_start     <= next_wd_start;
         from_pu      <= next_from_pu;
         rst_q        <= next_rst_q;
         eval_q       <= next_eval;
         frozen       <= next_frozen;
      end
   end

   // ---------------------------------------------------------------
   // Function enables
   // ---------------------------------------------------------------
   always_comb begin
      en          = '0;
      en.ls_brake = (mode == opmode_pkg::MODE_STOP || mode == opmode_pkg::MODE_SLEEP) &&
                    (park_brake_req || ov_brake_req);
      unique case (mode)
         opmode_pkg::MODE_INIT: begin
            en.main_reg_on = 1'b1;
            en.wd_en       = reset_out_level;
            en.wd_fixed    = 1'b1;
            en.lin_on      = sdm;
         end
         opmode_pkg::MODE_NORMAL: begin
            en.main_reg_on = 1'b1;
            en.wd_en       = cfg.wd_en;
            en.hs_en       = cfg.hs_en;
            en.bridge_en   = cfg.bridge_en;
            en.pump_en     = cfg.pump_en;
            en.amp_en      = cfg.amp_en;
            en.lin_on      = cfg.lin_on;
            en.lin_wake    = cfg.lin_wake;
            en.cs_en       = cfg.cs_en;
            en.cs_src      = cfg.cs_src;
            en.cw_en       = cfg.cw_en;
            en.cw_src      = cfg.cw_src;
         end
         opmode_pkg::MODE_STOP: begin
            en.main_reg_on = 1'b1;
            en.wd_en       = frozen.wd_en;
            en.wd_fixed    = 1'b1;
            en.hs_en       = frozen.hs_en;
            en.lin_on      = frozen.lin_on;
            en.lin_wake    = frozen.lin_wake;
            en.cs_en       = frozen.cs_en;
            en.cs_src      = frozen.cs_src;
            en.cw_en       = frozen.cw_en;
            en.cw_src      = frozen.cw_src;
         end
         opmode_pkg::MODE_SLEEP: begin
            en.hs_en    = frozen.hs_en;
            en.lin_wake = frozen.lin_wake;
            en.cs_en    = frozen.cs_en;
            en.cs_src   = frozen.cs_src;
            en.cw_en    = frozen.cw_en;
            en.cw_src   = frozen.cw_src;
         end
         opmode_pkg::MODE_RESTART: begin
            en.main_reg_on = 1'b1;
         end
         default: begin
            en.main_reg_on = 1'b1;
         end
      endcase
   end

   assign int_req = (mode == opmode_pkg::MODE_STOP) && |(wake_events & wake_mask);

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_init_outputs: assert property (mode == opmode_pkg::MODE_INIT |->
      en.main_reg_on && !en.hs_en && !en.bridge_en && !en.pump_en && !en.cs_en)
      else $error("init enables wrong");
   a_sdm_lin: assert property (mode == opmode_pkg::MODE_INIT |-> en.lin_on == sdm)
      else $error("init LIN not tied to development mode");
   a_stop_discard: assert property (mode == opmode_pkg::MODE_STOP && is_write &&
      !stop_allowed && !restart_req |=> spi_fault && !write_accept &&
      mode == opmode_pkg::MODE_STOP)
      else $error("stop write not discarded");
   a_stop_hold: assert property (mode == opmode_pkg::MODE_STOP && !frame.valid &&
      !restart_req |=> mode == opmode_pkg::MODE_STOP)
      else $error("stop left without command");
   a_stop_frozen: assert property ((mode == opmode_pkg::MODE_STOP)[*3] |->
      $stable(en.hs_en) && $stable(en.lin_on) && !en.bridge_en && !en.amp_en)
      else $error("stop outputs not frozen");
   a_sleep_off: assert property (mode == opmode_pkg::MODE_SLEEP |->
      !en.main_reg_on && !en.wd_en && !en.pump_en && !en.lin_on)
      else $error("sleep enables wrong");
   a_brake_path: assert property (mode == opmode_pkg::MODE_SLEEP &&
      (park_brake_req || ov_brake_req) |-> en.ls_brake)
      else $error("sleep brake blocked");
   a_crc_latch: assert property (rst_rise && eval_q |=> crc_en == !$past(strap_filt))
      else $error("CRC strap not latched");
   a_crc_on: assert property (mode == opmode_pkg::MODE_NORMAL && crc_mismatch &&
      frm_on && !(rst_rise && eval_q) |=> crc_en)
      else $error("CRC enable frame ignored");
   a_crc_off: assert property (mode == opmode_pkg::MODE_NORMAL && crc_mismatch &&
      frm_off && !(rst_rise && eval_q) |=> !crc_en)
      else $error("CRC disable frame ignored");
   a_crc_hold: assert property (!(rst_rise && eval_q) && !frm_on && !frm_off
      |=> $stable(crc_en))
      else $error("CRC setting changed");
   a_soft_rst: assert property (mode == opmode_pkg::MODE_STOP && is_write &&
      frame.kind == opmode_pkg::KIND_MODE && req == opmode_pkg::REQ_SOFT_RST &&
      !restart_req |=> mode == opmode_pkg::MODE_INIT && soft_reset ##1 !soft_reset)
      else $error("soft reset not taken");
   a_wd_start: assert property (mode == opmode_pkg::MODE_INIT && rst_rise
      |=> wd_start ##1 !wd_start)
      else $error("watchdog start missing");
   a_normal_cfg: assert property (mode == opmode_pkg::MODE_NORMAL |->
      en.pump_en == cfg.pump_en && en.cw_src == cfg.cw_src && en.main_reg_on)
      else $error("normal enables not from config");

   c_enter_stop: cover property (mode == opmode_pkg::MODE_NORMAL ##1
      mode == opmode_pkg::MODE_STOP);
   c_crc_recov: cover property (mode == opmode_pkg::MODE_NORMAL && crc_mismatch && frm_on);
   c_sdm: cover property (!sdm ##1 sdm);
   c_soft: cover property (soft_reset);
endmodule

// >>> bench/host_model.sv
// Host model: presents decoded SPI frames to the mode controller.
// Assumes the bench clock; frames change on the falling edge.
`timescale 1ns/1ps
module host_model (
   input  wire logic              clk,
   input  wire opmode_pkg::mode_t mode,
   output opmode_pkg::frame_t     frame
);
   initial begin
      frame = '0;
   end

   // One frame, valid for one cycle, then scrambled idle fields
   task automatic send(input logic [7:0] a, input logic [15:0] d, input logic [7:0] c,
                       input opmode_pkg::frame_kind_t k);
      @(negedge clk);
      frame = {1'b1, a, d, c, k};
      @(negedge clk);
      frame = {1'b0, ~frame[33:0]};
   endtask

   // Recovery frames go out in Normal only
   task automatic recover(input logic on);
      if (mode !== opmode_pkg::MODE_NORMAL) begin
         return;
      end
      if (on) begin
         send(opmode_pkg::CRC_ON_ADDR, opmode_pkg::RECOV_DATA, opmode_pkg::CRC_ON_CHK,
              opmode_pkg::KIND_OTHER);
      end else begin
         send(opmode_pkg::CRC_OFF_ADDR, opmode_pkg::RECOV_DATA, opmode_pkg::CRC_OFF_CHK,
              opmode_pkg::KIND_OTHER);
      end
   endtask
endmodule

// >>> bench/operating_mode_controller_test.sv
// Bench for the operating-mode controller.
// Assumes a 40 MHz clock and short strap and test pin filters.
`timescale 1ns/1ps
module operating_mode_controller_test;
   logic                 clk, reset_n, main_reg_ok, por_flag, reset_out_level, restart_req;
   logic                 crc_strap_pin, int_test_pin, crc_mismatch, fault_clear, seen;
   logic                 park_brake_req, ov_brake_req;
   logic                 crc_en, sdm, spi_fault, write_accept, soft_reset, wd_start, int_req;
   logic [3:0]           wake_events, wake_mask;
   opmode_pkg::frame_t   frame;
   opmode_pkg::cfg_t     cfg;
   opmode_pkg::mode_t    mode;
   opmode_pkg::enables_t en;
   int                   err_total, check_count;

   operating_mode_controller #(.STRAP_CYC(3), .TEST_CYC(3)) dut (
      .clk, .reset_n, .main_reg_ok, .por_flag, .reset_out_level, .restart_req,
      .crc_strap_pin, .int_test_pin, .frame, .crc_mismatch, .fault_clear, .cfg,
      .park_brake_req, .ov_brake_req, .wake_events, .wake_mask, .mode, .en, .crc_en,
      .sdm, .spi_fault, .write_accept, .soft_reset, .wd_start, .int_req
   );

   host_model host (.clk(clk), .mode(mode), .frame(frame));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic logic [11:0] en_cfg();
      return {en.wd_en, en.hs_en, en.bridge_en, en.pump_en, en.amp_en, en.lin_on, en.lin_wake,
              en.cs_en, en.cs_src, en.cw_en, en.cw_src};
   endfunction

   task automatic mode_req(input logic [15:0] d);
      host.send(8'h80, d, 8'h00, opmode_pkg::KIND_MODE);
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Tests take about 70 cycles
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      finish_test;
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      err_total = 0;
      check_count = 0;
      reset_n = 1'b0;
      main_reg_ok = 1'b1;
      por_flag = 1'b1;
      reset_out_level = 1'b0;
      restart_req = 1'b0;
      crc_strap_pin = 1'b0;
      int_test_pin = 1'b0;
      crc_mismatch = 1'b0;
      fault_clear = 1'b0;
      cfg = 12'hfff;
      park_brake_req = 1'b0;
      ov_brake_req = 1'b0;
      wake_events = 4'h0;
      wake_mask = 4'hf;
      seen = 1'b0;
      cyc(8);
      reset_n = 1'b1;
      cyc(1);
      compare(mode, opmode_pkg::MODE_INIT);
      compare({en.main_reg_on, en.wd_fixed, en.hs_en, en.bridge_en, en.pump_en, en.amp_en,
               en.lin_on, en.cs_en, en.cw_en}, 16'h0180);
      cyc(12);
      reset_out_level = 1'b1;
      repeat (4) begin
         @(negedge clk);
         seen |= wd_start;
      end
      compare(seen, 1'b1);
      compare(crc_en, 1'b1);
      host.send(8'h00, 16'h0000, 8'h00, opmode_pkg::KIND_STATUS);
      cyc(1);
      compare({sdm, en.lin_on}, 2'b11);
      $display("init test done");
      cfg = 12'hd7b;
      mode_req(16'h0000);
      compare({write_accept, mode}, {1'b1, opmode_pkg::MODE_NORMAL});
      compare(en_cfg(), 12'hd7b);
      wake_events = 4'h2;
      cyc(1);
      compare(int_req, 1'b0);
      crc_mismatch = 1'b1;
      host.send(opmode_pkg::CRC_OFF_ADDR, opmode_pkg::RECOV_DATA, 8'h00,
                opmode_pkg::KIND_OTHER);
      compare(crc_en, 1'b1);
      host.recover(1'b0);
      compare(crc_en, 1'b0);
      host.recover(1'b1);
      compare(crc_en, 1'b1);
      crc_mismatch = 1'b0;
      $display("normal test done");
      cfg = 12'hfff;
      mode_req(16'h0002);
      compare({mode, en.main_reg_on, en.bridge_en, en.pump_en, en.amp_en},
              {opmode_pkg::MODE_STOP, 4'h8});
      cfg = 12'h000;
      cyc(1);
      compare(en_cfg(), 12'hc7f);
      compare({int_req, mode}, {1'b1, opmode_pkg::MODE_STOP});
      wake_mask = 4'hd;
      cyc(1);
      compare(int_req, 1'b0);
      host.send(8'h85, 16'h1234, 8'h00, opmode_pkg::KIND_OTHER);
      compare({write_accept, spi_fault}, 2'b01);
      fault_clear = 1'b1;
      cyc(1);
      fault_clear = 1'b0;
      cyc(1);
      compare(spi_fault, 1'b0);
      host.send(8'h90, 16'h0000, 8'h00, opmode_pkg::KIND_WD_REF);
      compare({write_accept, spi_fault}, 2'b10);
      mode_req(16'h0001);
      compare({mode, spi_fault}, {opmode_pkg::MODE_STOP, 1'b1});
      park_brake_req = 1'b1;
      cyc(1);
      compare(en.ls_brake, 1'b1);
      park_brake_req = 1'b0;
      mode_req(16'h0003);
      compare({soft_reset, mode}, {1'b1, opmode_pkg::MODE_INIT});
      $display("stop test done");
      cfg = 12'hfff;
      mode_req(16'h0000);
      mode_req(16'h0001);
      compare({mode, en.main_reg_on, en.wd_en, en.bridge_en, en.pump_en, en.amp_en},
              {opmode_pkg::MODE_SLEEP, 5'h00});
      ov_brake_req = 1'b1;
      cyc(1);
      compare({en.ls_brake, en.hs_en, en.cs_en, en.cw_en, en.lin_wake}, 5'h1f);
      $display("sleep test done");
      restart_req = 1'b1;
      reset_out_level = 1'b0;
      crc_strap_pin = 1'b1;
      cyc(1);
      restart_req = 1'b0;
      compare(mode, opmode_pkg::MODE_RESTART);
      cyc(10);
      reset_out_level = 1'b1;
      cyc(1);
      compare({mode, crc_en, wd_start}, {opmode_pkg::MODE_NORMAL, 2'b00});
      $display("restart test done");
      finish_test;
   end
endmodule
